//--- src/fwp_pkg.sv
// Constants, opcodes and status bit layout for the flash write protect status block
package fwp_pkg;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int ADDR_W = 23;
    localparam logic [23:0] ARRAY_SPAN = 24'h800000;
    localparam logic [23:0] SIZE_ONE = 24'h000001;
    localparam logic [4:0] LOG_BASE_WIDE = 5'h10;
    localparam logic [4:0] LOG_BASE_SMALL = 5'h0B;
    localparam logic [2:0] SMALL_CODE_CAP = 3'h4;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_ALL = 3'h7;

    // ****************************************
    // Commands and register select
    // ****************************************
    typedef enum logic [3:0]
    {
        OP_NONE = 4'h0,
        OP_WRITE_ENABLE = 4'h1,
        OP_WRITE_DISABLE = 4'h2,
        OP_STATUS_WRITE = 4'h3,
        OP_PAGE_PROGRAM = 4'h4,
        OP_FOUR_KB_ERASE = 4'h5,
        OP_BLOCK_ERASE = 4'h6,
        OP_CHIP_ERASE = 4'h7,
        OP_SUSPEND = 4'h8,
        OP_RESUME = 4'h9,
        OP_SOFT_RESET = 4'hA
    } fwp_op_e;

    localparam logic [1:0] SEL_PROTECT_LOW = 2'h0;
    localparam logic [1:0] SEL_SUSPEND_QUAD = 2'h1;
    localparam logic [1:0] SEL_PIN_DRIVE = 2'h2;

    // ****************************************
    // First status register, bits 7..0
    // ****************************************
    localparam int BUSY_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam int BP_LSB = 2;
    localparam int BP_MSB = 6;
    localparam int LOCK_LO_BIT = 7;
    localparam logic [7:0] SR1_WR_MASK = 8'hFC;
    localparam logic [7:0] SR1_RESET = 8'h00;

    // ****************************************
    // Second status register, bits 15..8
    // ****************************************
    localparam int LOCK_HI_BIT = 0;
    localparam int QE_BIT = 1;
    localparam int PSUS_BIT = 2;
    localparam int LB_LSB = 3;
    localparam int LB_MSB = 5;
    localparam int CMP_BIT = 6;
    localparam int ESUS_BIT = 7;
    localparam logic [7:0] SR2_WR_MASK = 8'h7B;
    localparam logic [7:0] SR2_OTP_MASK = 8'h38;
    localparam logic [7:0] SR2_RESET = 8'h00;

    // ****************************************
    // Third status register, bits 23..16
    // ****************************************
    localparam int DC_BIT = 0;
    localparam int DRV_LO_BIT = 5;
    localparam int DRV_HI_BIT = 6;
    localparam int HOLD_RST_BIT = 7;
    localparam logic [7:0] SR3_WR_MASK = 8'hE1;
    localparam logic [7:0] SR3_RESET = 8'h20;

endpackage : fwp_pkg

//--- src/fwp_decode.sv
// Protected area decode of the block protect bits and complement select
`timescale 1ns/100ps
module fwp_decode
(
    input wire logic [4:0] block_protect,
    input wire logic complement_select,
    input wire logic [fwp_pkg::ADDR_W-1:0] addr,
    output logic protected_hit,
    output logic chip_erase_ok
);
    logic [2:0] code;
    logic [2:0] small_code;
    logic [4:0] size_log;
    logic [23:0] size;
    logic [23:0] addr_w;
    logic normal_area;

    always_comb
    begin
        code = block_protect[2:0];
        small_code = (code > fwp_pkg::SMALL_CODE_CAP) ? fwp_pkg::SMALL_CODE_CAP : code;
        // Wide rows start at 128KB, small rows at 4KB, capped at 32KB
        if (!block_protect[4])
        begin
            size_log = fwp_pkg::LOG_BASE_WIDE + {2'h0, code};
        end
        else
        begin
            size_log = fwp_pkg::LOG_BASE_SMALL + {2'h0, small_code};
        end
        size = fwp_pkg::SIZE_ONE << size_log;
        addr_w = {1'h0, addr};
        // Normal decode; bit 3 picks bottom or top of array
        if (code == fwp_pkg::CODE_NONE)
        begin
            normal_area = 1'b0;
        end
        else if (code == fwp_pkg::CODE_ALL)
        begin
            normal_area = 1'b1;
        end
        else if (block_protect[3])
        begin
            normal_area = addr_w < size;
        end
        else
        begin
            normal_area = addr_w >= (fwp_pkg::ARRAY_SPAN - size);
        end
        // Complemented decode is the inverse area
        protected_hit = complement_select ? !normal_area : normal_area;
        chip_erase_ok = complement_select ? (code == fwp_pkg::CODE_ALL)
                                          : (code == fwp_pkg::CODE_NONE);
    end

endmodule : fwp_decode

//--- src/fwp_status.sv
// Status registers, write enable latch and protection gate of the serial flash
//
// Contract
// - Complement on, code 000: whole array protected
// - Complement on, 00 rows: lower areas
// - Complement on, 01 rows: upper areas
// - Complement on, 10 rows: lower, small top gap
// - Complement on, 11 rows: upper, small bottom gap
// - Complement off, 111 rows: bottom 32KB, except code 111 whole array
// - Busy and latch bits 0,1 read only
// - Protect bits 2..6, status lock bit 7
// - Suspend flags bits 15 and 10, read only
// - Complement select bit 14 picks decode
// - Secure area locks 11..13 one time
// - Quad enable bit 9, lock hi 8
// - Pin select 23, drive strength 22..21
// - Dummy cycle bit 16, 17..20 reserved
// - Chip erase only when nothing protected
// - Latch clear refuses writes, programs, erases
// - Latch clears on reset, disable, completion
`timescale 1ns/100ps
module fwp_status
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [1:0] cmd_sel,
    input wire logic [7:0] cmd_data,
    input wire logic [fwp_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic array_done,
    output logic [7:0] status_protect_low,
    output logic [7:0] status_suspend_quad,
    output logic [7:0] status_pin_drive_config,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic array_start,
    output logic [3:0] array_op
);

    // ****************************************
    // Protection decode
    // ****************************************
    logic protected_hit;
    logic chip_erase_ok;

    fwp_decode u_decode
    (
        .block_protect(status_protect_low[fwp_pkg::BP_MSB:fwp_pkg::BP_LSB]),
        .complement_select(status_suspend_quad[fwp_pkg::CMP_BIT]),
        .addr(cmd_addr),
        .protected_hit(protected_hit),
        .chip_erase_ok(chip_erase_ok)
    );

    // ****************************************
    // Next state
    // ****************************************
    logic [7:0] next_sr1;
    logic [7:0] next_sr2;
    logic [7:0] next_sr3;
    logic next_accept;
    logic next_reject;
    logic next_start;
    logic [3:0] next_array_op;
    logic [3:0] active_op;
    logic [3:0] next_active_op;
    logic busy_now;
    logic write_ok;

    always_comb
    begin
        next_sr1 = status_protect_low;
        next_sr2 = status_suspend_quad;
        next_sr3 = status_pin_drive_config;
        next_accept = 1'b0;
        next_reject = 1'b0;
        next_start = 1'b0;
        next_array_op = array_op;
        next_active_op = active_op;
        // Completion ends busy and drops the latch
        if (array_done && status_protect_low[fwp_pkg::BUSY_BIT])
        begin
            next_sr1[fwp_pkg::BUSY_BIT] = 1'b0;
            next_sr1[fwp_pkg::WEL_BIT] = 1'b0;
        end
        busy_now = next_sr1[fwp_pkg::BUSY_BIT];
        write_ok = !busy_now && next_sr1[fwp_pkg::WEL_BIT];
        if (cmd_valid)
        begin
            next_reject = 1'b1;
            unique case (cmd_op)
                fwp_pkg::OP_WRITE_ENABLE:
                begin
                    if (!busy_now)
                    begin
                        next_sr1[fwp_pkg::WEL_BIT] = 1'b1;
                        next_reject = 1'b0;
                    end
                end
                fwp_pkg::OP_WRITE_DISABLE:
                begin
                    if (!busy_now)
                    begin
                        next_sr1[fwp_pkg::WEL_BIT] = 1'b0;
                        next_reject = 1'b0;
                    end
                end
                fwp_pkg::OP_STATUS_WRITE:
                begin
                    if (write_ok && !status_suspend_quad[fwp_pkg::LOCK_HI_BIT])
                    begin
                        next_reject = 1'b0;
                        next_sr1[fwp_pkg::WEL_BIT] = 1'b0;
                        // Masks keep read-only and reserved bits
                        if (cmd_sel == fwp_pkg::SEL_PROTECT_LOW)
                        begin
                            next_sr1 = (next_sr1 & ~fwp_pkg::SR1_WR_MASK)
                                     | (cmd_data & fwp_pkg::SR1_WR_MASK);
                        end
                        else if (cmd_sel == fwp_pkg::SEL_SUSPEND_QUAD)
                        begin
                            next_sr2 = (status_suspend_quad & ~fwp_pkg::SR2_WR_MASK)
                                     | (cmd_data & fwp_pkg::SR2_WR_MASK)
                                     | (status_suspend_quad & fwp_pkg::SR2_OTP_MASK);
                        end
                        else if (cmd_sel == fwp_pkg::SEL_PIN_DRIVE)
                        begin
                            next_sr3 = cmd_data & fwp_pkg::SR3_WR_MASK;
                        end
                        else
                        begin
                            // Refused select keeps the latch set
                            next_reject = 1'b1;
                            next_sr1[fwp_pkg::WEL_BIT] = 1'b1;
                        end
                    end
                end
                fwp_pkg::OP_PAGE_PROGRAM, fwp_pkg::OP_FOUR_KB_ERASE,
                fwp_pkg::OP_BLOCK_ERASE, fwp_pkg::OP_CHIP_ERASE:
                begin
                    // Refused ones start nothing and leave busy unchanged
                    if (write_ok && ((cmd_op == fwp_pkg::OP_CHIP_ERASE) ? chip_erase_ok
                                                                      : !protected_hit))
                    begin
                        next_reject = 1'b0;
                        next_sr1[fwp_pkg::BUSY_BIT] = 1'b1;
                        next_start = 1'b1;
                        next_array_op = cmd_op;
                        next_active_op = cmd_op;
                    end
                end
                fwp_pkg::OP_SUSPEND:
                begin
                    if (busy_now)
                    begin
                        next_reject = 1'b0;
                        next_sr1[fwp_pkg::BUSY_BIT] = 1'b0;
                        next_start = 1'b1;
                        next_array_op = cmd_op;
                        if (active_op == fwp_pkg::OP_PAGE_PROGRAM)
                        begin
                            next_sr2[fwp_pkg::PSUS_BIT] = 1'b1;
                        end
                        else
                        begin
                            next_sr2[fwp_pkg::ESUS_BIT] = 1'b1;
                        end
                    end
                end
                fwp_pkg::OP_RESUME:
                begin
                    if (status_suspend_quad[fwp_pkg::PSUS_BIT]
                        || status_suspend_quad[fwp_pkg::ESUS_BIT])
                    begin
                        next_reject = 1'b0;
                        next_sr2[fwp_pkg::PSUS_BIT] = 1'b0;
                        next_sr2[fwp_pkg::ESUS_BIT] = 1'b0;
                        next_sr1[fwp_pkg::BUSY_BIT] = 1'b1;
                        next_start = 1'b1;
                        next_array_op = active_op;
                    end
                end
                fwp_pkg::OP_SOFT_RESET:
                begin
                    // Volatile bits only; stored settings survive
                    next_reject = 1'b0;
                    next_sr1[fwp_pkg::BUSY_BIT] = 1'b0;
                    next_sr1[fwp_pkg::WEL_BIT] = 1'b0;
                    next_sr2[fwp_pkg::PSUS_BIT] = 1'b0;
                    next_sr2[fwp_pkg::ESUS_BIT] = 1'b0;
                    next_start = 1'b1;
                    next_array_op = cmd_op;
                end
                default:
                begin
                    next_reject = 1'b1;
                end
            endcase
            next_accept = !next_reject;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            status_protect_low <= fwp_pkg::SR1_RESET;
            status_suspend_quad <= fwp_pkg::SR2_RESET;
            status_pin_drive_config <= fwp_pkg::SR3_RESET;
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            array_start <= 1'b0;
            array_op <= fwp_pkg::OP_NONE;
            active_op <= fwp_pkg::OP_NONE;
        end
        else
        begin
            status_protect_low <= next_sr1;
            status_suspend_quad <= next_sr2;
            status_pin_drive_config <= next_sr3;
            cmd_accept <= next_accept;
            cmd_reject <= next_reject;
            array_start <= next_start;
            array_op <= next_array_op;
            active_op <= next_active_op;
        end
    end

endmodule : fwp_status

//--- verif/fwp_sva.sv
// Port-level assertions for the flash write protect status block
`timescale 1ns/100ps
module fwp_sva
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [1:0] cmd_sel,
    input wire logic [7:0] cmd_data,
    input wire logic [fwp_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic array_done,
    input wire logic [7:0] status_protect_low,
    input wire logic [7:0] status_suspend_quad,
    input wire logic [7:0] status_pin_drive_config,
    input wire logic cmd_accept,
    input wire logic cmd_reject,
    input wire logic array_start,
    input wire logic [3:0] array_op
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire busy = status_protect_low[0];
    wire write_enable_latch = status_protect_low[1];
    wire cmp = status_suspend_quad[6];
    wire [2:0] code = status_protect_low[4:2];
    wire pe = cmd_valid && cmd_op >= 4'h4 && cmd_op <= 4'h6;

    a_latch_gate: assert property (cmd_valid && cmd_op >= 4'h3 && cmd_op <= 4'h7 && !write_enable_latch
        |=> cmd_reject) else $error("write accepted without latch");
    a_busy_ro: assert property (cmd_valid && cmd_op == 4'h3 && !busy && cmd_sel != 2'h3
        && !status_suspend_quad[0] |=> !busy && !write_enable_latch) else $error("status write moved busy");
    a_disable_clear: assert property (cmd_valid && cmd_op == 4'h2 && !busy
        |=> cmd_accept && !write_enable_latch) else $error("latch not cleared");
    a_refuse_quiet: assert property (cmd_valid && !busy && cmd_op >= 4'h4 && cmd_op <= 4'h7
        ##1 cmd_reject |-> !busy && !array_start) else $error("refused op started");
    a_susp_ro: assert property (cmd_valid && cmd_op == 4'h3 && cmd_sel == 2'h1
        |=> $stable(status_suspend_quad[7]) && $stable(status_suspend_quad[2]))
        else $error("suspend flag written");
    a_otp_keep: assert property (1'b1
        |=> ($past(status_suspend_quad[5:3]) & ~status_suspend_quad[5:3]) == 3'h0)
        else $error("secure lock cleared");
    a_rsvd_zero: assert property (status_pin_drive_config[4:1] == 4'h0)
        else $error("reserved bits set");
    a_chip_gate: assert property (cmd_valid && cmd_op == 4'h7
        && !(code == 3'h0 && !cmp || code == 3'h7 && cmp) |=> cmd_reject)
        else $error("chip erase not refused");
    a_all_prot: assert property (pe && cmp && code == 3'h0 |=> cmd_reject)
        else $error("whole array not protected");
    a_none_prot: assert property (cmd_valid && cmd_op == 4'h4 && cmp && code == 3'h7 && write_enable_latch
        && !busy |=> cmd_accept && array_start && array_op == 4'h4) else $error("program refused");
    a_bottom_prot: assert property (pe && !cmp && status_protect_low[6:4] == 3'h7
        && status_protect_low[3:2] != 2'h3 && cmd_addr < 23'h008000 |=> cmd_reject)
        else $error("bottom area not protected");
endmodule : fwp_sva

bind fwp_status fwp_sva u_sva (.clk_sys, .rst, .cmd_valid, .cmd_op, .cmd_sel, .cmd_data,
    .cmd_addr, .array_done, .status_protect_low, .status_suspend_quad, .status_pin_drive_config,
    .cmd_accept, .cmd_reject, .array_start, .array_op);

//--- verif/fwp_array_model.sv
// Array engine model that ends each started operation after a set delay
`timescale 1ns/100ps
module fwp_array_model
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic array_start,
    input wire logic [3:0] array_op,
    input wire logic [3:0] delay,
    output logic array_done
);
    logic [4:0] count;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count <= 5'h00;
            array_done <= 1'b0;
        end
        else
        begin
            array_done <= count == 5'h01;
            // Suspend and soft reset stop the running operation
            if (array_start)
                count <= (array_op == 4'h8 || array_op == 4'hA) ? 5'h00 : {1'b0, delay} + 5'h01;
            else if (count != 5'h00)
                count <= count - 5'h01;
        end
    end
endmodule : fwp_array_model

//--- verif/test_flash_write_protect_status.sv
// Self-checking bench for the flash write protect status block
`timescale 1ns/100ps
module test_flash_write_protect_status;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_op = 4'h0;
    logic [1:0] cmd_sel = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic [22:0] cmd_addr = 23'h000000;
    logic [3:0] delay = 4'h1;
    logic array_done, cmd_accept, cmd_reject, array_start;
    logic [3:0] array_op;
    logic [7:0] status_protect_low, status_suspend_quad, status_pin_drive_config, rnd;
    logic [1:0] exp_q[$];
    logic [51:0] rows[9];
    int mismatches = 0;
    int tests_run = 0;
    int seed = 96;
    int i;

    always #12.5 clk_sys = ~clk_sys;

    fwp_status uut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_sel(cmd_sel), .cmd_data(cmd_data), .cmd_addr(cmd_addr), .array_done(array_done),
        .status_protect_low(status_protect_low), .status_suspend_quad(status_suspend_quad),
        .status_pin_drive_config(status_pin_drive_config), .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject), .array_start(array_start), .array_op(array_op));
    fwp_array_model u_engine (.clk_sys(clk_sys), .rst(rst), .array_start(array_start),
        .array_op(array_op), .delay(delay), .array_done(array_done));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic cmd(input logic [3:0] op, input logic [1:0] sel, input logic [7:0] data,
        input logic [22:0] addr, input logic ok);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_sel <= sel;
        cmd_data <= data;
        cmd_addr <= addr;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        exp_q.push_back({ok, ~ok});
        #1;
    endtask : cmd

    task automatic wait_idle;
        int n;
        for (n = 0; n < 100 && status_protect_low[0] !== 1'b0; n++)
            @(negedge clk_sys);
        if (n == 100)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask : wait_idle

    // Complement and protect code, then latch set for a program
    task automatic setprot(input logic c, input logic [4:0] bp);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h1, {1'b0, c, 6'h00}, 23'h0, 1'b1);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h0, {1'b0, bp, 2'h0}, 23'h0, 1'b1);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
    endtask : setprot

    // Outcome order check of accept and refuse pulses
    always @(negedge clk_sys)
        if (cmd_accept || cmd_reject)
            check({6'h00, cmd_accept, cmd_reject}, {6'h00, exp_q.pop_front()});

    initial
    begin
        // Complement, code, refused address, allowed address
        rows = '{{1'b1, 5'h01, 23'h7DFFFF, 23'h7E0000}, {1'b1, 5'h06, 23'h3FFFFF, 23'h400000},
            {1'b1, 5'h09, 23'h020000, 23'h01FFFF}, {1'b1, 5'h0E, 23'h400000, 23'h3FFFFF},
            {1'b1, 5'h11, 23'h7FEFFF, 23'h7FF000}, {1'b1, 5'h15, 23'h7F7FFF, 23'h7F8000},
            {1'b1, 5'h1B, 23'h004000, 23'h003FFF}, {1'b1, 5'h1E, 23'h008000, 23'h007FFF},
            {1'b0, 5'h1C, 23'h007FFF, 23'h008000}};
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check(status_protect_low, 8'h00);
        check(status_suspend_quad, 8'h00);
        check(status_pin_drive_config, 8'h20);
        cmd(4'h3, 2'h0, 8'hFF, 23'h0, 1'b0);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h2, 2'h0, 8'h00, 23'h0, 1'b1);
        check(status_protect_low, 8'h00);
        rnd = $random(seed) & 8'hE1;
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h2, rnd, 23'h0, 1'b1);
        check(status_pin_drive_config, rnd);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h3, 8'hFF, 23'h0, 1'b0);
        check(status_protect_low, 8'h02);
        setprot(1'b0, 5'h1C);
        check(status_protect_low, 8'h72);
        for (i = 0; i < 9; i++)
        begin
            setprot(rows[i][51], rows[i][50:46]);
            delay <= 4'($random(seed));
            cmd(4'h4, 2'h0, 8'h00, rows[i][45:23], 1'b0);
            check(status_protect_low[0], 1'b0);
            cmd(4'h4, 2'h0, 8'h00, rows[i][22:0], 1'b1);
            wait_idle();
            check(status_protect_low[1], 1'b0);
        end
        setprot(1'b1, 5'h18);
        cmd(4'h5, 2'h0, 8'h00, 23'($random(seed)), 1'b0);
        cmd(4'h7, 2'h0, 8'h00, 23'h0, 1'b0);
        setprot(1'b1, 5'h07);
        cmd(4'h7, 2'h0, 8'h00, 23'h0, 1'b1);
        wait_idle();
        delay <= 4'hF;
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h4, 2'h0, 8'h00, 23'($random(seed)), 1'b1);
        cmd(4'h8, 2'h0, 8'h00, 23'h0, 1'b1);
        check(status_suspend_quad[2], 1'b1);
        cmd(4'h9, 2'h0, 8'h00, 23'h0, 1'b1);
        check(status_suspend_quad[2], 1'b0);
        check({4'h0, array_op}, 8'h04);
        wait_idle();
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h5, 2'h0, 8'h00, 23'($random(seed)), 1'b1);
        cmd(4'h8, 2'h0, 8'h00, 23'h0, 1'b1);
        check(status_suspend_quad[7], 1'b1);
        cmd(4'hA, 2'h0, 8'h00, 23'h0, 1'b1);
        check(status_suspend_quad, 8'h40);
        check(status_protect_low, 8'h1C);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h1, 8'hB8, 23'h0, 1'b1);
        check(status_suspend_quad, 8'h38);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h1, 8'h03, 23'h0, 1'b1);
        check(status_suspend_quad, 8'h3B);
        cmd(4'h1, 2'h0, 8'h00, 23'h0, 1'b1);
        cmd(4'h3, 2'h0, 8'h00, 23'h0, 1'b0);
        cmd(4'hA, 2'h0, 8'h00, 23'h0, 1'b1);
        check(status_protect_low[1], 1'b0);
        report_and_stop();
    end
endmodule : test_flash_write_protect_status
